// ### mrr_pkg.sv
/*
 Constants, command codes and timing counts for the mode register read path.
 Assumes a single 250 MHz clock shared by the controller end and the device end.
*/
`default_nettype none
// How it works
// RQ1: CS low, CA[2:0] low, CA3 high decodes read
// RQ2: Address from falling CA1:0, rising CA9:4
// RQ3: Register byte on DQ[7:0] first beat after latency
// RQ4: Other beats and upper lanes carry filler
// RQ5: Strobes toggle through the whole burst
// RQ6: Every register read bursts exactly four beats
// RQ7: Controller never interrupts a register read
// RQ8: Controller waits two cycles after read command
// RQ9: Only no-operations during the command period
// RQ10: Write waits latency plus access plus three
// RQ11: Register write waits the same spacing
// RQ12: Register read never truncates a running burst
// RQ13: After read, wait burst_len/2 cycles
// RQ14: After write, wait WL+1+BL/2+write_to_read
// RQ15: Truncated bursts use effective length for spacing; code always uses full BURST_LEN/2
// RQ16: Temperature status in temp_status_reg bits 2:0
// RQ17: Temperature status refreshed at most every 32 ms
// RQ18: Controller polls temperature fast enough for margin; mrr_ctrl never polls, reads only on request
// RQ19: Pattern A 1010, pattern B 0011 per beat
// RQ20: Pattern reads copy lowest lane across byte
// RQ21: Pattern reads only while device idle
// RQ22: Read works with banks idle or active
package mrr_pkg;
    localparam int DQ_W = 16;
    localparam int CA_W = 10;
    localparam logic [3:0] CMD_MRR = 4'h8;
    localparam logic [3:0] CMD_MRW = 4'h0;
    localparam logic [7:0] ADDR_TEMP = 8'h04;
    localparam logic [7:0] ADDR_CAL_A = 8'h20;
    localparam logic [7:0] ADDR_CAL_B = 8'h28;
    localparam logic [3:0] CAL_A_BITS = 4'h5;
    localparam logic [3:0] CAL_B_BITS = 4'hc;
    localparam logic [7:0] FILLER = 8'ha5;
    localparam int READ_LATENCY = 3;
    localparam int WRITE_LATENCY = 1;
    localparam int BURST_LEN = 4;
    localparam int BEATS = 4;
    localparam int MRR_CMD_PERIOD = 2;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int DQSCK_MAX_PS = 5500;
    localparam int WTR_PS = 7500;
    localparam int DQSCK_CYC = (DQSCK_MAX_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WTR_CYC = (WTR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MRR_TO_WR = READ_LATENCY + DQSCK_CYC + BEATS / 2 + 1;
    localparam int RD_TO_MRR = BURST_LEN / 2;
    localparam int WR_TO_MRR = WRITE_LATENCY + 1 + BURST_LEN / 2 + WTR_CYC;
    localparam int TSI_MS = 32;
    localparam int CLK_MHZ = 250;
    localparam longint TSI_CYC = longint'(TSI_MS) * 1000 * CLK_MHZ;
    localparam int TEMP_W = 3;
    localparam logic [2:0] TEMP_RESET = 3'h3;
endpackage
`default_nettype wire

// ### mrr_if.sv
/*
 Link between controller and device: command/address and data with strobes.
 Assumes both ends share clk; the controller qualifies the data bus with dq_oe.
*/
`timescale 1ns/1ps
`default_nettype none
interface mrr_if;
    import mrr_pkg::*;
    logic cs_n;
    logic [CA_W-1:0] ca_rise;
    logic [CA_W-1:0] ca_fall;
    logic [DQ_W-1:0] dq_out;
    logic dq_oe;
    logic [1:0] dqs_out;
    logic dqs_oe;
    modport device (input cs_n, ca_rise, ca_fall, output dq_out, dq_oe, dqs_out, dqs_oe);
    modport ctrl (output cs_n, ca_rise, ca_fall, input dq_out, dq_oe, dqs_out, dqs_oe);
endinterface
`default_nettype wire

// ### mrr_device.sv
/*
 Device end: decodes register reads and returns a four-beat burst.
 Assumes the controller keeps its spacing; link inputs cross from pins via two flops.
*/
`timescale 1ns/1ps
`default_nettype none
module mrr_device
    import mrr_pkg::*;
#(
    parameter longint TSI_CYCLES = TSI_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link
    mrr_if.device link,
    // Sensor and activity
    input wire logic [TEMP_W-1:0] sensor_temp,
    input wire logic burst_busy,
    output logic [TEMP_W-1:0] temp_status,
    output logic mrr_busy
);
    typedef enum logic [1:0] {IDLE, WAIT_LAT, BURST} state_e;

    // ****************
    // Input synchroniser
    // ****************
    logic cs_n_s1_reg, cs_n_s2_reg;
    logic [CA_W-1:0] car_s1_reg, car_s2_reg, caf_s1_reg, caf_s2_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            cs_n_s1_reg <= 1'b1;
            cs_n_s2_reg <= 1'b1;
            car_s1_reg <= '0;
            car_s2_reg <= '0;
            caf_s1_reg <= '0;
            caf_s2_reg <= '0;
        end else begin
            cs_n_s1_reg <= link.cs_n;
            cs_n_s2_reg <= cs_n_s1_reg;
            car_s1_reg <= link.ca_rise;
            car_s2_reg <= car_s1_reg;
            caf_s1_reg <= link.ca_fall;
            caf_s2_reg <= caf_s1_reg;
        end
    end

    // ****************
    // Temperature status
    // ****************
    logic [TEMP_W-1:0] temp_reg, temp_next;
    logic [31:0] tsi_cnt_reg, tsi_cnt_next;
    always_comb begin
        temp_next = temp_reg;
        tsi_cnt_next = tsi_cnt_reg + 32'h1;
        if (tsi_cnt_reg >= 32'(TSI_CYCLES - 1)) begin
            tsi_cnt_next = '0;
            temp_next = sensor_temp; // RQ17
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            temp_reg <= TEMP_RESET;
            tsi_cnt_reg <= '0;
        end else begin
            temp_reg <= temp_next;
            tsi_cnt_reg <= tsi_cnt_next;
        end
    end

    // ****************
    // Read sequencer
    // ****************
    state_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] addr_reg, addr_next;
    logic [DQ_W-1:0] dq_reg, dq_next;
    logic dq_oe_reg, dq_oe_next;
    logic [1:0] dqs_reg, dqs_next;
    logic dqs_oe_reg, dqs_oe_next;
    logic is_mrr;
    logic [7:0] cmd_addr;
    logic cal;
    logic bitv;

    always_comb begin
        is_mrr = !cs_n_s2_reg && car_s2_reg[3:0] == CMD_MRR; // RQ1
        cmd_addr = {car_s2_reg[9:4], caf_s2_reg[1:0]}; // RQ2
        cal = addr_reg == ADDR_CAL_A || addr_reg == ADDR_CAL_B;
        bitv = addr_reg == ADDR_CAL_A ? CAL_A_BITS[cnt_reg[1:0]] : CAL_B_BITS[cnt_reg[1:0]]; // RQ19
        state_next = state_reg;
        cnt_next = cnt_reg;
        addr_next = addr_reg;
        dq_next = dq_reg;
        dq_oe_next = 1'b0;
        dqs_next = 2'b00;
        dqs_oe_next = 1'b0;
        case (state_reg)
            IDLE: begin
                // Bank state is never touched here
                if (is_mrr && !burst_busy) begin // RQ12 RQ22
                    addr_next = cmd_addr;
                    cnt_next = 4'(READ_LATENCY - 1);
                    state_next = WAIT_LAT;
                end
            end
            WAIT_LAT: begin
                if (cnt_reg == 4'h0) begin // RQ3
                    state_next = BURST;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            BURST: begin
                dq_oe_next = 1'b1;
                dqs_oe_next = 1'b1;
                dqs_next = cnt_reg[0] ? 2'b00 : 2'b11; // RQ5
                if (cal) begin
                    dq_next = {DQ_W{bitv}}; // RQ20
                end else if (cnt_reg == 4'h0) begin
                    dq_next = {FILLER, addr_reg == ADDR_TEMP ? {5'h00, temp_reg} : 8'h00}; // RQ3 RQ16
                end else begin
                    dq_next = {FILLER, FILLER}; // RQ4
                end
                if (cnt_reg == 4'(BEATS - 1)) begin // RQ6
                    state_next = IDLE;
                    cnt_next = '0;
                end else begin
                    cnt_next = cnt_reg + 4'h1;
                end
            end
            default: state_next = IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= IDLE;
            cnt_reg <= '0;
            addr_reg <= '0;
            dq_reg <= '0;
            dq_oe_reg <= 1'b0;
            dqs_reg <= 2'b00;
            dqs_oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            dq_reg <= dq_next;
            dq_oe_reg <= dq_oe_next;
            dqs_reg <= dqs_next;
            dqs_oe_reg <= dqs_oe_next;
        end
    end

    logic busy_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= state_next != IDLE;
        end
    end

    assign link.dq_out = dq_reg;
    assign link.dq_oe = dq_oe_reg;
    assign link.dqs_out = dqs_reg;
    assign link.dqs_oe = dqs_oe_reg;
    assign temp_status = temp_reg;
    assign mrr_busy = busy_reg;
endmodule // mrr_device
`default_nettype wire

// ### mrr_ctrl.sv
/*
 Controller end: issues register reads with legal spacing and captures beat 0.
 Assumes the device answers per the link timing; data inputs pass two flops.
*/
`timescale 1ns/1ps
`default_nettype none
module mrr_ctrl
    import mrr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link
    mrr_if.ctrl link,
    // User request
    input wire logic req_valid,
    input wire logic [7:0] req_addr,
    input wire logic prev_read,
    input wire logic prev_write,
    input wire logic dev_idle,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic [3:0] rsp_cal
);
    typedef enum logic [1:0] {READY, HOLD, COLLECT} state_e;

    logic oe_s1_reg, oe_s2_reg;
    logic [DQ_W-1:0] dq_s1_reg, dq_s2_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            oe_s1_reg <= 1'b0;
            oe_s2_reg <= 1'b0;
            dq_s1_reg <= '0;
            dq_s2_reg <= '0;
        end else begin
            oe_s1_reg <= link.dq_oe;
            oe_s2_reg <= oe_s1_reg;
            dq_s1_reg <= link.dq_out;
            dq_s2_reg <= dq_s1_reg;
        end
    end

    state_e state_reg, state_next;
    logic [3:0] gap_reg, gap_next, beat_reg, beat_next;
    logic cs_n_reg, cs_n_next;
    logic [CA_W-1:0] car_reg, car_next, caf_reg, caf_next;
    logic rv_reg, rv_next, rdy_reg, rdy_next;
    logic [7:0] rd_reg, rd_next;
    logic [3:0] rc_reg, rc_next;
    logic ok;

    always_comb begin
        // RQ13 RQ14 RQ15 RQ21
        ok = gap_reg == 4'h0 && (!(req_addr == ADDR_CAL_A || req_addr == ADDR_CAL_B) || dev_idle);
        state_next = state_reg;
        gap_next = gap_reg == 4'h0 ? 4'h0 : gap_reg - 4'h1;
        if (prev_write) begin
            gap_next = 4'(WR_TO_MRR);
        end else if (prev_read && gap_next < 4'(RD_TO_MRR)) begin
            gap_next = 4'(RD_TO_MRR);
        end
        beat_next = beat_reg;
        cs_n_next = 1'b1; // RQ9
        car_next = '0;
        caf_next = '0;
        rv_next = 1'b0;
        rdy_next = 1'b0;
        rd_next = rd_reg;
        rc_next = rc_reg;
        case (state_reg)
            READY: begin
                rdy_next = ok && !prev_read && !prev_write; // RQ13 RQ14
                if (req_valid && rdy_reg && !prev_read && !prev_write) begin
                    cs_n_next = 1'b0;
                    car_next = {req_addr[7:2], CMD_MRR}; // RQ1 RQ2
                    caf_next = {8'h00, req_addr[1:0]};
                    gap_next = 4'(MRR_TO_WR); // RQ8 RQ10 RQ11
                    state_next = HOLD;
                end
            end
            HOLD: begin
                if (oe_s2_reg) begin // RQ7
                    rd_next = dq_s2_reg[7:0];
                    rc_next = {3'h0, dq_s2_reg[0]};
                    beat_next = 4'h1;
                    state_next = COLLECT;
                end
            end
            COLLECT: begin
                rc_next[beat_reg[1:0]] = dq_s2_reg[0];
                if (beat_reg == 4'(BEATS - 1)) begin
                    rv_next = 1'b1;
                    state_next = READY;
                end else begin
                    beat_next = beat_reg + 4'h1;
                end
            end
            default: state_next = READY;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= READY;
            gap_reg <= '0;
            beat_reg <= '0;
            cs_n_reg <= 1'b1;
            car_reg <= '0;
            caf_reg <= '0;
            rv_reg <= 1'b0;
            rdy_reg <= 1'b0;
            rd_reg <= '0;
            rc_reg <= '0;
        end else begin
            state_reg <= state_next;
            gap_reg <= gap_next;
            beat_reg <= beat_next;
            cs_n_reg <= cs_n_next;
            car_reg <= car_next;
            caf_reg <= caf_next;
            rv_reg <= rv_next;
            rdy_reg <= rdy_next;
            rd_reg <= rd_next;
            rc_reg <= rc_next;
        end
    end

    assign link.cs_n = cs_n_reg;
    assign link.ca_rise = car_reg;
    assign link.ca_fall = caf_reg;
    assign req_ready = rdy_reg;
    assign rsp_valid = rv_reg;
    assign rsp_data = rd_reg;
    assign rsp_cal = rc_reg;
endmodule // mrr_ctrl
`default_nettype wire

// ### mrr_checker.sv
/*
 Checker for the link between controller and device ends.
 Assumes it watches the interface signals on clk, reset synchronous high.
*/
`timescale 1ns/1ps
`default_nettype none
module mrr_checker
    import mrr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link
    input wire logic cs_n,
    input wire logic [CA_W-1:0] ca_rise,
    input wire logic [CA_W-1:0] ca_fall,
    input wire logic [DQ_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic [1:0] dqs_out,
    input wire logic dqs_oe
);
    logic [7:0] addr_reg;
    logic [7:0] addr_next;
    logic cal;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ****************
    // Address capture
    // ****************
    assign cal = addr_reg == ADDR_CAL_A || addr_reg == ADDR_CAL_B;
    always_comb begin
        addr_next = addr_reg;
        if (!cs_n && ca_rise[3:0] == CMD_MRR) begin
            addr_next = {ca_rise[9:4], ca_fall[1:0]};
        end
    end
    always_ff @(posedge clk) begin
        addr_reg <= reset ? 8'h00 : addr_next;
    end
    // ****************
    // Sequences and assertions
    // ****************
    sequence s_cmd;
        !cs_n && ca_rise[3:0] == CMD_MRR;
    endsequence
    sequence s_lane0(logic [3:0] b);
        dq_out[0] == b[0] ##1 dq_out[0] == b[1] ##1 dq_out[0] == b[2] ##1 dq_out[0] == b[3];
    endsequence
    a_burst_four_beats: assert property ($rose(dq_oe) |-> dq_oe [*4] ##1 !dq_oe)
        else $error("burst length wrong");
    a_strobe_with_data: assert property (dq_oe == dqs_oe && (dqs_oe -> dqs_out[0] == dqs_out[1]))
        else $error("strobe enable wrong");
    a_strobe_toggles: assert property (dqs_oe && $past(dqs_oe) |-> dqs_out == ~$past(dqs_out))
        else $error("strobe not toggling");
    a_data_latency: assert property (s_cmd |-> ##7 $rose(dq_oe))
        else $error("read data late");
    a_no_cmd_burst: assert property (dq_oe |-> cs_n)
        else $error("command during burst");
    a_cmd_period_nop: assert property (s_cmd |=> cs_n [*2])
        else $error("command inside read period");
    a_cal_lanes_equal: assert property (dq_oe && cal |-> dq_out == {DQ_W{dq_out[0]}})
        else $error("pattern lanes differ");
    a_cal_a_pattern: assert property ($rose(dq_oe) && addr_reg == ADDR_CAL_A |-> s_lane0(4'h5))
        else $error("pattern a wrong");
    a_cal_b_pattern: assert property ($rose(dq_oe) && addr_reg == ADDR_CAL_B |-> s_lane0(4'hc))
        else $error("pattern b wrong");
    a_filler_beats: assert property ($rose(dq_oe) && !cal |->
        dq_out[15:8] == FILLER ##1 (dq_out == {FILLER, FILLER}) [*3])
        else $error("filler wrong");
endmodule // mrr_checker
`default_nettype wire

// ### test_sdram_mode_register_read.sv
/*
 Testbench joining controller and device ends through the link interface.
 Assumes a 250 MHz clock and a short sensor update period.
*/
`timescale 1ns/1ps
`default_nettype none
module test_sdram_mode_register_read;
    import mrr_pkg::*;
    logic clk;
    logic reset;
    logic [2:0] sensor_temp;
    logic req_valid;
    logic [7:0] req_addr;
    logic prev_read;
    logic prev_write;
    logic dev_idle;
    logic req_ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic [3:0] rsp_cal;
    logic [2:0] temp_status;
    logic mrr_busy;
    logic [7:0] d;
    logic [3:0] c;
    int bad_count;
    int n_checks;
    int cycles;
    int n;
    int kind;
    mrr_if link();
    mrr_device #(.TSI_CYCLES(16)) u_mrr_device (.clk(clk), .reset(reset), .link(link),
        .sensor_temp(sensor_temp), .burst_busy(1'b0), .temp_status(temp_status), .mrr_busy(mrr_busy));
    mrr_ctrl u_mrr_ctrl (.clk(clk), .reset(reset), .link(link), .req_valid(req_valid),
        .req_addr(req_addr), .prev_read(prev_read), .prev_write(prev_write), .dev_idle(dev_idle),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_cal(rsp_cal));
    mrr_checker u_mrr_checker (.clk(clk), .reset(reset), .cs_n(link.cs_n), .ca_rise(link.ca_rise),
        .ca_fall(link.ca_fall), .dq_out(link.dq_out), .dq_oe(link.dq_oe), .dqs_out(link.dqs_out),
        .dqs_oe(link.dqs_oe));
    // ****************
    // Tasks
    // ****************
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    function automatic logic [3:0] exp_cal(input logic [7:0] ad);
        return ad == ADDR_CAL_A ? 4'h5 : 4'hc;
    endfunction
    // Request, count refused edges, then collect response unless refused
    task automatic mrr(input logic [7:0] ad, input int k);
        n = 0;
        req_addr <= ad;
        prev_read <= k == 1;
        prev_write <= k == 2;
        @(posedge clk);
        prev_read <= 1'b0;
        prev_write <= 1'b0;
        req_valid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 40);
        req_valid <= 1'b0;
        if (n < 40) begin
            do @(posedge clk); while (rsp_valid !== 1'b1 && n++ < 80);
            chk("rsp_valid", 16'h1, {15'h0, rsp_valid});
            d = rsp_data;
            c = rsp_cal;
        end
        repeat (12) @(posedge clk);
        chk("mrr_busy idle", 16'h0, {15'h0, mrr_busy});
    endtask
    // ****************
    // Clock, timeout, sequence
    // ****************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'h02e1));
        reset = 1'b1;
        sensor_temp = 3'h6;
        req_valid = 1'b0;
        req_addr = 8'h00;
        prev_read = 1'b0;
        prev_write = 1'b0;
        dev_idle = 1'b1;
        bad_count = 0;
        n_checks = 0;
        cycles = 0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        chk("temp_status reset", 16'h3, {13'h0, temp_status});
        repeat (40) @(posedge clk);
        chk("temp_status update", 16'h6, {13'h0, temp_status});
        mrr(ADDR_TEMP, 0);
        chk("temp read", 16'h6, {13'h0, d[2:0]});
        mrr(ADDR_CAL_A, 0);
        chk("pattern a", {12'h0, exp_cal(ADDR_CAL_A)}, {12'h0, c});
        mrr(ADDR_CAL_B, 1);
        chk("pattern b", {12'h0, exp_cal(ADDR_CAL_B)}, {12'h0, c});
        dev_idle <= 1'b0;
        req_addr <= ADDR_CAL_A;
        repeat (3) @(posedge clk);
        mrr(ADDR_CAL_A, 0);
        chk("pattern refused", 16'd40, 16'(n));
        dev_idle <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            kind = $urandom % 3;
            sensor_temp <= 3'($urandom);
            mrr(i < 2 ? ADDR_CAL_A : 8'($urandom), kind);
            if (kind != 0) begin
                chk("spacing", 16'h1, {15'h0, n >= (kind == 1 ? RD_TO_MRR : WR_TO_MRR)});
            end
        end
        give_verdict();
    end
endmodule // test_sdram_mode_register_read
`default_nettype wire
